// *** src/counter_array_pkg.sv ***
// package: register map, field positions and reset values of the counter array control block
package counter_array_pkg;

  // ****************************************************************
  // register byte offsets on the apb bus
  // ****************************************************************
  localparam logic [11:0] ADDR_CONTROL_STATUS = 12'h000;
  localparam logic [11:0] ADDR_MODE           = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS     = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK       = 12'h00c;
  localparam logic [11:0] ADDR_COUNT          = 12'h010;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int OVF_BIT      = 7;
  localparam int RUN_BIT      = 6;
  localparam int RSVD_BIT     = 5;
  localparam int NUM_MODULES  = 5;
  localparam int IRQ_EN_BIT   = 0;
  localparam int COUNT_WIDTH  = 16;
  localparam int IRQ_OVF_BIT  = 0;
  localparam int IRQ_MOD_BIT  = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;

endpackage : counter_array_pkg

// *** src/counter_event_if.sv ***
// interface: run, overflow and count between the array counter and the register bank
`timescale 1ns/1ps
interface counter_event_if;
  logic       run;         // counter enable from the run bit
  logic       overflow;    // one-cycle pulse at rollover
  logic [15:0] count;      // current counter value
  modport counter (input run, output overflow, output count);
  modport bank    (output run, input overflow, input count);
endinterface : counter_event_if

// *** src/array_counter.sv ***
// module: shared 16-bit counter of the counter array
`timescale 1ns/1ps
module array_counter (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // count tick and event link
  input  wire logic count_tick,
  counter_event_if.counter ev
);

  logic [15:0] count_reg;
  logic        ovf_reg;
  wire  logic  step   = clk_en & ev.run & count_tick;
  wire  logic  at_max = (count_reg == counter_array_pkg::COUNT_MAX);

  // counter advances only while running
  // counter run gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= counter_array_pkg::COUNT_RESET;
      ovf_reg   <= 1'b0;
    end else if (clk_en) begin
      ovf_reg <= step & at_max;
      if (step) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  assign ev.overflow = ovf_reg & clk_en;
  assign ev.count    = count_reg;

  chk_stopped_no_count: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !ev.run) |=> $stable(count_reg)) else $error("counter moved while stopped");

endmodule // array_counter

// *** src/event_flag_bank.sv ***
// module: sticky flag bank with hardware set priority over software clear
`timescale 1ns/1ps
module event_flag_bank #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // hardware set and software write
  input  wire logic [WIDTH-1:0] hw_set,
  input  wire logic             sw_write,
  input  wire logic [WIDTH-1:0] sw_data,
  // flags
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_next;

  // per-flag next value: set wins, only software zero clears
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
      assign flags_next[i] = hw_set[i] | (sw_write ? sw_data[i] : flags[i]);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else if (clk_en) begin
      flags <= flags_next;
    end
  end

  chk_set_wins_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && (hw_set != '0)) |=> ((flags & $past(hw_set)) == $past(hw_set)))
    else $error("hardware set lost");

  chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (!sw_write) |=> ((flags & $past(flags)) == $past(flags)))
    else $error("flag cleared without software write");

endmodule // event_flag_bank

// *** src/counter_array_control_status.sv ***
// module: counter array control/status register bank on apb
`timescale 1ns/1ps
module counter_array_control_status (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // counter array events
  input  wire logic        count_tick,
  input  wire logic [4:0]  module_event,
  // status outputs
  output logic             counter_run_out,
  output logic             array_irq_req,
  output logic             irq
);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire logic access  = psel & penable & clk_en;
  // write commits only on the completing edge, while pready stands
  wire logic commit  = access & pready;
  wire logic wr      = commit & pwrite;
  wire logic hit_ctl = (paddr == counter_array_pkg::ADDR_CONTROL_STATUS);
  wire logic hit_mod = (paddr == counter_array_pkg::ADDR_MODE);
  wire logic hit_ist = (paddr == counter_array_pkg::ADDR_IRQ_STATUS);
  wire logic hit_msk = (paddr == counter_array_pkg::ADDR_IRQ_MASK);
  wire logic hit_cnt = (paddr == counter_array_pkg::ADDR_COUNT);
  wire logic mapped  = hit_ctl | hit_mod | hit_ist | hit_msk | hit_cnt;
  wire logic wr_ctl  = wr & hit_ctl;

  // ****************************************************************
  // registers and link
  // ****************************************************************
  counter_event_if ev ();
  logic       run_reg;
  logic [7:0] mode_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [5:0] flags;
  logic [7:0] ctl_view;
  logic [5:0] hw_set;
  logic       mod_event_any;

  // run bit
  // run control bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= counter_array_pkg::CONTROL_RESET[counter_array_pkg::RUN_BIT];
    end else if (wr_ctl) begin
      run_reg <= pwdata[counter_array_pkg::RUN_BIT];
    end
  end
  assign ev.run = run_reg;

  // mode register, only the enable bit is kept
  // enable from mode bit 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= counter_array_pkg::MODE_RESET;
    end else if (wr & hit_mod) begin
      mode_reg <= {7'h00, pwdata[counter_array_pkg::IRQ_EN_BIT]};
    end
  end

  array_counter u_counter (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .count_tick (count_tick),
    .ev         (ev.counter)
  );

  // flags: bits 4..0 modules, bit 5 of the bank is the overflow flag
  // rollover sets overflow
  assign hw_set = {ev.overflow, module_event};

  event_flag_bank #(.WIDTH(6)) u_flags (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .hw_set   (hw_set),
    .sw_write (wr_ctl),
    .sw_data  ({pwdata[counter_array_pkg::OVF_BIT], pwdata[4:0]}),
    .flags    (flags)
  );

  // control/status read view, reserved bit reads zero
  // reserved bit ignored
  assign ctl_view = {flags[5], run_reg, 1'b0, flags[4:0]};

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  assign mod_event_any = |module_event;

  // sticky status, write one clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= counter_array_pkg::IRQ_RESET;
      irq_mask_reg   <= counter_array_pkg::IRQ_RESET;
    end else if (clk_en) begin
      irq_status_reg <= {mod_event_any, ev.overflow} |
                        (irq_status_reg & ~((wr & hit_ist) ? pwdata[1:0] : 2'h0));
      if (wr & hit_msk) begin
        irq_mask_reg <= pwdata[1:0];
      end
    end
  end

  // outputs registered
  // overflow interrupt request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      array_irq_req   <= 1'b0;
      irq             <= 1'b0;
      counter_run_out <= 1'b0;
    end else if (clk_en) begin
      array_irq_req   <= flags[5] & mode_reg[counter_array_pkg::IRQ_EN_BIT];
      irq             <= |(irq_status_reg & irq_mask_reg);
      counter_run_out <= run_reg;
    end
  end

  // ****************************************************************
  // apb response, one wait state
  // ****************************************************************
  logic [31:0] rdata_mux;
  assign rdata_mux = hit_ctl ? {24'h000000, ctl_view} :
                     hit_mod ? {24'h000000, mode_reg} :
                     hit_ist ? {30'h0, irq_status_reg} :
                     hit_msk ? {30'h0, irq_mask_reg} :
                     hit_cnt ? {16'h0000, ev.count} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata_mux : 32'h00000000;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // interrupt follows flag and enable
  chk_irq_req_follows: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> (array_irq_req == $past(flags[5] & mode_reg[0]))) else $error("irq req mismatch");

  chk_overflow_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ev.overflow) |=> flags[5]) else $error("overflow flag not set");

  chk_module_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && module_event[2]) |=> flags[2]) else $error("module flag not set");

  chk_run_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl |=> (run_reg == $past(pwdata[6]))) else $error("run bit not written");

  chk_sw_sets_ovf: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctl && pwdata[7]) |=> flags[5]) else $error("software set of overflow lost");

  chk_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_mod) |=> (mode_reg[0] == $past(pwdata[0]))) else $error("enable not stored");

  chk_flag_mapping: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl_view[4:0] == flags[4:0]) && !ctl_view[5]) else $error("flag mapping wrong");

  chk_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (flags[0] && !wr_ctl) |=> flags[0]) else $error("module flag dropped");

  // apb answer one cycle after access start
  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(penable) && psel && clk_en && !commit) |=> pready) else $error("pready late");

endmodule // counter_array_control_status

// *** testbench/counter_array_control_status_tb.sv ***
// testbench: apb-driven checks of the counter array control/status register bank
`timescale 1ns/1ps
module counter_array_control_status_tb;
  // ****************************************************************
  // signals and counters
  // ****************************************************************
  logic        pclk, presetn, clk_en, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rd2;
  logic        pready, pslverr, count_tick, counter_run_out, array_irq_req, irq, er;
  logic [4:0]  module_event, ev;
  logic [7:0]  wv;
  int          err_count, compares, n;

  counter_array_control_status counter_array_control_status_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_tick(count_tick), .module_event(module_event),
    .counter_run_out(counter_run_out), .array_irq_req(array_irq_req), .irq(irq));

  // 50 ns clock
  always #25 pclk = ~pclk;

  // ****************************************************************
  // report, compare and bus tasks
  // ****************************************************************
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    err_count++;
    final_report();
  endtask

  // one apb transfer; e pulses module events at the commit edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [4:0] e, output logic [31:0] r, output logic s);
    int k;
    @(posedge pclk);
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    k = 0;
    // events stand in every wait cycle, so they meet the commit edge
    while (pready !== 1'b1) begin
      module_event <= e;
      if (k++ > 20) hang();
      @(posedge pclk);
    end
    module_event <= 5'h00;
    r = prdata; s = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic pulse(input logic [4:0] e);
    @(posedge pclk); module_event <= e;
    @(posedge pclk); module_event <= 5'h00;
  endtask

  // expected control value after a write racing hardware event sets
  function automatic logic [31:0] ctrl_after(input logic [7:0] w, input logic [4:0] e);
    return {24'h0, (w & 8'hdf) | {3'h0, e}};
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    pclk = 1'b0; presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; count_tick = 1'b0;
    module_event = 5'h00; err_count = 0; compares = 0;
    void'($urandom(65));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b0, 32'h0, 5'h00, rd, er);
    check(rd, {24'h0, counter_array_pkg::CONTROL_RESET});
    apb(counter_array_pkg::ADDR_COUNT, 1'b0, 32'h0, 5'h00, rd, er);
    check(rd, {16'h0, counter_array_pkg::COUNT_RESET});
    check({29'h0, irq, array_irq_req, counter_run_out}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      pulse(5'h01 << i);
      apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b0, 32'h0, 5'h00, rd, er);
      check(rd, 32'h1 << i);
      apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b0, 32'h0, 5'h00, rd, er);
      check(rd, 32'h1 << i);
      wv = 8'($urandom) & 8'hdf;
      ev = 5'($urandom);
      apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b1, {24'h0, wv}, ev, rd, er);
      // registered run output lags the commit edge by one cycle
      repeat (2) @(posedge pclk);
      check({31'h0, counter_run_out}, {31'h0, wv[6]});
      apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b0, 32'h0, 5'h00, rd, er);
      check(rd, ctrl_after(wv, ev));
      apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b1, 32'h0, 5'h00, rd, er);
      apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b0, 32'h0, 5'h00, rd, er);
      check(rd, 32'h0);
    end
    apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b1, 32'h0, 5'h1f, rd, er);
    apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b0, 32'h0, 5'h00, rd, er);
    check(rd, 32'h1f);
    $display("test event flags done");
    apb(counter_array_pkg::ADDR_IRQ_MASK, 1'b1, 32'h2, 5'h00, rd, er);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(counter_array_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0, 5'h00, rd, er);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(counter_array_pkg::ADDR_IRQ_MASK, 1'b1, 32'h2, 5'h00, rd, er);
    apb(counter_array_pkg::ADDR_IRQ_STATUS, 1'b1, 32'h3, 5'h00, rd, er);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(counter_array_pkg::ADDR_IRQ_STATUS, 1'b0, 32'h0, 5'h00, rd, er);
    check(rd & 32'h2, 32'h0);
    pulse(5'h04);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    $display("test interrupt done");
    apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b1, 32'h80, 5'h00, rd, er);
    apb(counter_array_pkg::ADDR_MODE, 1'b1, 32'hff, 5'h00, rd, er);
    apb(counter_array_pkg::ADDR_MODE, 1'b0, 32'h0, 5'h00, rd, er);
    check(rd, 32'h1);
    repeat (2) @(posedge pclk);
    check({31'h0, array_irq_req}, 32'h1);
    apb(counter_array_pkg::ADDR_MODE, 1'b1, 32'h0, 5'h00, rd, er);
    repeat (2) @(posedge pclk);
    check({31'h0, array_irq_req}, 32'h0);
    apb(counter_array_pkg::ADDR_MODE, 1'b1, 32'h1, 5'h00, rd, er);
    apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b1, 32'h0, 5'h00, rd, er);
    repeat (2) @(posedge pclk);
    check({31'h0, array_irq_req}, 32'h0);
    apb(12'h020, 1'b0, 32'h0, 5'h00, rd, er);
    check({rd[30:0], er}, 32'h1);
    apb(12'h020, 1'b1, 32'hffff_ffff, 5'h00, rd, er);
    check({31'h0, er}, 32'h1);
    $display("test irq enable and unmapped done");
    apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b1, 32'h40, 5'h00, rd, er);
    count_tick <= 1'b1;
    apb(counter_array_pkg::ADDR_COUNT, 1'b0, 32'h0, 5'h00, rd, er);
    apb(counter_array_pkg::ADDR_COUNT, 1'b0, 32'h0, 5'h00, rd2, er);
    check({31'h0, rd2 > rd}, 32'h1);
    apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b1, 32'h0, 5'h00, rd, er);
    apb(counter_array_pkg::ADDR_COUNT, 1'b0, 32'h0, 5'h00, rd, er);
    apb(counter_array_pkg::ADDR_COUNT, 1'b0, 32'h0, 5'h00, rd2, er);
    check(rd2, rd);
    apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b1, 32'h40, 5'h00, rd, er);
    n = 0;
    while (array_irq_req !== 1'b1) begin
      if (n++ > 70000) hang();
      @(posedge pclk);
    end
    count_tick <= 1'b0;
    apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b0, 32'h0, 5'h00, rd, er);
    check(rd, 32'hc0);
    repeat (20) @(posedge pclk);
    apb(counter_array_pkg::ADDR_CONTROL_STATUS, 1'b0, 32'h0, 5'h00, rd, er);
    check(rd, 32'hc0);
    $display("test run and overflow done");
    final_report();
  end
endmodule // counter_array_control_status_tb
